/* rtl/spirp_cfg.svh */
// Purpose : Constants for the serial register port (offsets, fields, resets, frame sizes)
// Assumes : Included by the port logic and its checker, by bare name
// Notes   : Definitions only, no logic
`ifndef SPIRP_CFG_SVH
`define SPIRP_CFG_SVH

// Register address width and data width of one frame byte
`define SPIRP_ADDR_W         7
`define SPIRP_DATA_W         8
// Last bit index within one byte of a frame
`define SPIRP_LAST_BIT       3'h7
// Register that holds the three-wire enable bit
`define SPIRP_ADDR_IFCONF    7'h34
// Bit position of the three-wire enable within that register
`define SPIRP_POS_THREE_WIRE 2
// Burst reads starting here do not advance the address
`define SPIRP_ADDR_FIFO_OUT  7'h3F
// Reset values
`define SPIRP_RST_THREE_WIRE 1'b0
`define SPIRP_RST_ADDR       7'h00
`define SPIRP_RST_BYTE       8'h00
// Synchroniser depth for pins from outside the clock domain
`define SPIRP_SYNC_STAGES    2

`endif

/* rtl/spirp_pkg.sv */
// Purpose : Types for the serial register port
// Assumes : Used by scoped name only, never imported
// Notes   : Constants live in spirp_cfg.svh
package spirp_pkg;

  // Frame sequencer states
  typedef enum logic [2:0] {
    SPIRP_ST_IDLE,
    SPIRP_ST_CTRL,
    SPIRP_ST_WDATA,
    SPIRP_ST_RDATA,
    SPIRP_ST_HOLD
  } spirp_state_t;

  // Clock mode caught at the start of a frame
  typedef enum logic {
    SPIRP_MODE_00,
    SPIRP_MODE_11
  } spirp_mode_t;

endpackage

/* rtl/spirp_sync.sv */
// Purpose : Two-flop synchroniser for a group of asynchronous pins
// Assumes : Each bit is an independent level; no word coherence across bits
// Notes   : First stage is read by the second stage only
`timescale 1ns/1ns
`include "spirp_cfg.svh"

module spirp_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,   // System clock
  input  wire logic             nrst,  // Async reset, active low
  input  wire logic [WIDTH-1:0] d,     // Asynchronous levels
  output logic      [WIDTH-1:0] q      // Synchronised levels
);

  // Refuse a width the logic cannot serve
  if (WIDTH < 1) begin : g_bad_width
    $error("spirp_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;

  // Both stages reset to zero; the pins settle within two edges after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* rtl/spirp_top.sv */
// Purpose : Serial slave port giving a host master access to the byte-wide register map
// Assumes : clk at 125 MHz, far faster than the serial clock; register file answers in-cycle
// Notes   : Serial clock and chip select are oversampled, not used as clocks
//           Read strobe also fires after the last burst byte, as a prefetch
//
// Overview of operation
// R01 - Select pin low enables port, high disables
// R02 - Four-wire: output, input, select, clock pins
// R03 - Starts four-wire; enable bit switches three-wire
// R04 - Modes 00/11, picked by clock at select
// R05 - Sixteen-bit frame: control byte then data
// R06 - Master frames with select and drives clock
// R07 - Change data on falling, sample on rising
// R08 - Data output stays released during writes
// R09 - First control bit: zero write, one read
// R10 - Seven address bits then eight data bits
// R11 - Burst read needs one control byte only
// R12 - Address advances after each byte read
// R13 - Three-wire: input pin is shared data line
// R14 - Three-wire keeps same frame and edges
// R15 - Master idles between writes: 2/450 us
// R16 - Burst from FIFO output address never advances
// R17 - Three-wire drives line only in read data
// R18 - Select rising mid-frame aborts, drops partial write
`timescale 1ns/1ns
`include "spirp_cfg.svh"

module spirp_top #(
  parameter int ADDR_W = `SPIRP_ADDR_W,
  parameter int DATA_W = `SPIRP_DATA_W
) (
  input  wire logic              clk,                 // System clock, 125 MHz
  input  wire logic              nrst,                // Async reset, active low
  input  wire logic              protocol_select_pin, // Low selects this port
  input  wire logic              chip_select_n,       // Frame select, active low
  input  wire logic              shared_clock_pin,    // Serial clock from master
  input  wire logic              shared_data_in,      // Data pin, input side
  output logic                   shared_data_out,     // Data pin, output side
  output logic                   shared_data_oe,      // Data pin drive enable
  output logic                   data_out_pin,        // Four-wire data output
  output logic                   data_out_oe,         // Four-wire output enable
  output logic [ADDR_W-1:0]      reg_addr,            // Register address
  output logic [DATA_W-1:0]      reg_wdata,           // Register write data
  output logic                   reg_wr,              // Write strobe, one cycle
  output logic                   reg_rd,              // Read strobe, one cycle
  input  wire logic [DATA_W-1:0] reg_rdata,           // Read data, valid with reg_rd
  output logic                   three_wire_enable,   // Three-wire configuration
  output logic                   clock_mode_11        // Mode caught at frame start
);

  // Refuse widths the frame format cannot carry
  if (ADDR_W + 1 != DATA_W || DATA_W != `SPIRP_DATA_W) begin : g_bad_width
    $error("spirp_top: frame needs ADDR_W+1 == DATA_W == 8");
  end

  // Next burst address; the FIFO output address is drained in place
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic              hold);
    next_addr = hold ? a : a + {{(ADDR_W-1){1'b0}}, 1'b1};
  endfunction

  // Byte after one more sampled bit, first bit ending up on top
  function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] b,
                                                 input logic              bit_in);
    shift_in = {b[DATA_W-2:0], bit_in};
  endfunction

  // ---------------------------------------------------------------- pins
  logic [3:0] pins_s;
  logic       ps_s;
  logic       csn_s;
  logic       sck_s;
  logic       sdi_s;
  logic       csn_q;
  logic       sck_q;

  // All four pins come from the master's domain. Select is carried inverted,
  // so the zero that the stages hold in reset reads as deselected: no false
  // frame start while the stages fill after reset release
  spirp_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({protocol_select_pin, ~chip_select_n, shared_clock_pin, shared_data_in}),
    .q    (pins_s)
  );

  assign ps_s  = pins_s[3];
  assign csn_s = ~pins_s[2];                      // Back to active-low sense
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // Delayed copies for edge finding; select copy resets high so no false select edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      csn_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      csn_q <= csn_s;
      sck_q <= sck_s;
    end
  end

  // ---------------------------------------------------------------- decode
  logic port_en;
  logic frame_on;
  logic frame_start;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;

  assign port_en     = ~ps_s;                     // [R01]
  assign frame_on    = port_en & ~csn_s;          // [R06]
  assign frame_start = port_en & ~csn_s & csn_q;  // [R06]
  // Edges only count inside a frame, so idle clock wiggles are ignored
  assign sck_rise    = frame_on & sck_s & ~sck_q; // [R07]
  assign sck_fall    = frame_on & ~sck_s & sck_q; // [R07]

  // ---------------------------------------------------------------- sequencer
  spirp_pkg::spirp_state_t st_q;
  spirp_pkg::spirp_state_t st_d;
  logic [2:0]              bit_cnt_q;
  logic [DATA_W-1:0]       rx_q;
  logic [DATA_W-1:0]       rx_next;
  logic [DATA_W-1:0]       tx_q;
  logic                    hold_addr_q;

  assign rx_next   = shift_in(rx_q, sdi_s);       // [R07]
  assign byte_done = sck_rise & (bit_cnt_q == `SPIRP_LAST_BIT);

  // State decodes, read by the register side and the transmit logic
  logic in_ctrl;
  logic in_wdata;
  logic in_rdata;

  assign in_ctrl   = (st_q == spirp_pkg::SPIRP_ST_CTRL);
  assign in_wdata  = (st_q == spirp_pkg::SPIRP_ST_WDATA);
  assign in_rdata  = (st_q == spirp_pkg::SPIRP_ST_RDATA);

  // Next state; select high or port disabled always wins
  always_comb begin
    st_d = st_q;
    if (!frame_on) begin
      st_d = spirp_pkg::SPIRP_ST_IDLE;            // [R18]
    end else begin
      case (st_q)
        spirp_pkg::SPIRP_ST_IDLE: begin
          if (frame_start) begin
            st_d = spirp_pkg::SPIRP_ST_CTRL;      // [R05]
          end
        end
        spirp_pkg::SPIRP_ST_CTRL: begin
          if (byte_done) begin
            // First bit of the control byte picks the direction
            st_d = rx_next[DATA_W-1] ? spirp_pkg::SPIRP_ST_RDATA
                                     : spirp_pkg::SPIRP_ST_WDATA; // [R09]
          end
        end
        spirp_pkg::SPIRP_ST_WDATA: begin
          if (byte_done) begin
            st_d = spirp_pkg::SPIRP_ST_HOLD;      // [R05]
          end
        end
        spirp_pkg::SPIRP_ST_RDATA: st_d = spirp_pkg::SPIRP_ST_RDATA; // [R11]
        spirp_pkg::SPIRP_ST_HOLD:  st_d = spirp_pkg::SPIRP_ST_HOLD;
        default:                   st_d = spirp_pkg::SPIRP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= spirp_pkg::SPIRP_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Bit counter and receive shifter; cleared at every frame start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= 3'h0;
      rx_q      <= `SPIRP_RST_BYTE;
    end else if (frame_start || !frame_on) begin
      bit_cnt_q <= 3'h0;                          // [R18]
      rx_q      <= `SPIRP_RST_BYTE;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q      <= rx_next;
    end
  end

  // Clock mode is the serial clock level seen as select falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clock_mode_11 <= 1'b0;
    end else if (frame_start) begin
      clock_mode_11 <= sck_s;                     // [R04]
    end
  end

  // ---------------------------------------------------------------- register side
  logic ctrl_done;
  logic wr_done;
  logic rd_next;
  logic is_write_ctrl;
  logic cfg_hit;

  assign ctrl_done     = in_ctrl & byte_done;
  assign is_write_ctrl = ~rx_next[DATA_W-1];
  assign wr_done       = in_wdata & byte_done;
  assign rd_next       = in_rdata & byte_done;
  // Block snoops its own write to the interface config register
  assign cfg_hit       = wr_done & (reg_addr == `SPIRP_ADDR_IFCONF); // [R03]

  // Address: taken from the control byte, then advanced per byte read except at the FIFO output address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_addr    <= `SPIRP_RST_ADDR;
      hold_addr_q <= 1'b0;
    end else if (ctrl_done) begin
      reg_addr    <= rx_next[ADDR_W-1:0];         // [R10]
      hold_addr_q <= (rx_next[ADDR_W-1:0] == `SPIRP_ADDR_FIFO_OUT); // [R16]
    end else if (rd_next) begin
      reg_addr    <= next_addr(reg_addr, hold_addr_q); // [R12] [R16]
    end
  end

  // Strobes; a write strobe only after all eight data bits, so a cut frame writes nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_wdata <= `SPIRP_RST_BYTE;
    end else begin
      reg_wr <= wr_done;                          // [R05] [R18]
      reg_rd <= (ctrl_done & ~is_write_ctrl) | rd_next; // [R11]
      if (wr_done) begin
        reg_wdata <= rx_next;                     // [R10]
      end
    end
  end

  // Three-wire enable mirrors the bit written to the interface config register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      three_wire_enable <= `SPIRP_RST_THREE_WIRE; // [R03]
    end else if (cfg_hit) begin
      three_wire_enable <= rx_next[`SPIRP_POS_THREE_WIRE]; // [R03]
    end
  end

  // ---------------------------------------------------------------- transmit
  logic rd_phase;
  logic tx_load;
  logic out4_off;
  logic out3_off;

  assign rd_phase = in_rdata;
  // Line release; a write frame never reaches the read phase
  assign out4_off = ~frame_on | three_wire_enable | ~rd_phase;  // [R08] [R13]
  assign out3_off = ~frame_on | ~three_wire_enable | ~rd_phase; // [R17]
  // Register file answers in the strobe cycle; the next falling edge is far later
  assign tx_load  = reg_rd;

  // Transmit shifter, first bit out is the top bit
  // Mode 00 ends with one more falling edge; that last shift is never sent
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_q <= `SPIRP_RST_BYTE;
    end else if (tx_load) begin
      tx_q <= reg_rdata;                          // [R10]
    end else if (rd_phase && sck_fall) begin
      tx_q <= {tx_q[DATA_W-2:0], 1'b0};           // [R07]
    end
  end

  // Four-wire output: driven only during read data bytes, released otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_out_pin <= 1'b0;
      data_out_oe  <= 1'b0;
    end else if (out4_off) begin
      data_out_oe  <= 1'b0;                       // [R08] [R13]
    end else if (sck_fall) begin
      data_out_pin <= tx_q[DATA_W-1];             // [R02] [R07]
      data_out_oe  <= 1'b1;
    end
  end

  // Three-wire shared line: driven only in read data, released when select rises
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shared_data_out <= 1'b0;
      shared_data_oe  <= 1'b0;
    end else if (out3_off) begin
      shared_data_oe  <= 1'b0;                    // [R17]
    end else if (sck_fall) begin
      shared_data_out <= tx_q[DATA_W-1];          // [R13] [R14]
      shared_data_oe  <= 1'b1;                    // [R17]
    end
  end

endmodule

/* tb/spirp_top_sva.sv */
// Purpose: port checker for the serial register port
// Assumes: bound into spirp_top, single clock domain
// Notes: all properties are off while nrst is low
`timescale 1ns/1ns
`include "spirp_cfg.svh"
module spirp_top_sva #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input wire logic              clk,                 // Clock
  input wire logic              nrst,                // Reset, active low
  input wire logic              protocol_select_pin, // Port select
  input wire logic              chip_select_n,       // Frame select
  input wire logic              data_out_oe,         // 4-wire enable
  input wire logic              shared_data_oe,      // Shared enable
  input wire logic [ADDR_W-1:0] reg_addr,            // Address
  input wire logic [DATA_W-1:0] reg_wdata,           // Write data
  input wire logic              reg_wr,              // Write strobe
  input wire logic              reg_rd,              // Read strobe
  input wire logic              three_wire_enable    // Config level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Select high long enough to pass the synchroniser
  sequence cs_idle_s;
    chip_select_n [*6];
  endsequence
  sequence pin_off_s;
    protocol_select_pin [*6];
  endsequence
  oe4_wire4_a: assert property (data_out_oe |-> !three_wire_enable)
    else $error("four-wire output driven in three-wire");
  oe3_wire3_a: assert property (shared_data_oe |-> three_wire_enable)
    else $error("shared line driven in four-wire");
  cs_release_a: assert property (cs_idle_s |-> !data_out_oe && !shared_data_oe)
    else $error("output driven with select high");
  cs_quiet_a: assert property (cs_idle_s |-> !reg_wr && !reg_rd)
    else $error("strobe with select high");
  port_off_a: assert property (pin_off_s |-> !reg_wr && !reg_rd && !data_out_oe)
    else $error("activity while port deselected");
  strobe_excl_a: assert property (reg_wr |-> !reg_rd)
    else $error("read and write strobe together");
  wr_spacing_a: assert property (reg_wr |=> !reg_wr [*8])
    else $error("write strobes too close");
  rd_spacing_a: assert property (reg_rd |=> !reg_rd [*8])
    else $error("read strobes too close");
  cfg_write_a: assert property (reg_wr && reg_addr == `SPIRP_ADDR_IFCONF |->
    three_wire_enable == reg_wdata[`SPIRP_POS_THREE_WIRE])
    else $error("three-wire bit not taken from write");
  cfg_cause_a: assert property ($changed(three_wire_enable) |->
    reg_wr && reg_addr == `SPIRP_ADDR_IFCONF)
    else $error("three-wire bit changed without write");
  wr_silent_a: assert property (reg_wr |-> !data_out_oe && !shared_data_oe)
    else $error("data line driven in a write frame");
endmodule
bind spirp_top spirp_top_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
  .clk(clk), .nrst(nrst), .protocol_select_pin(protocol_select_pin),
  .chip_select_n(chip_select_n), .data_out_oe(data_out_oe),
  .shared_data_oe(shared_data_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .three_wire_enable(three_wire_enable));

/* tb/spirp_master.sv */
// Purpose: host master model driving frames on the serial link
// Assumes: link clock period of 125 ns, unrelated to clk
// Notes: released data shows the inverse of the last bit
`timescale 1ns/1ns
module spirp_master (
  output logic      cs_n, // Select, active low
  output logic      sck,  // Serial clock
  output logic      mosi, // Master data
  input  wire logic sdo,  // 4-wire return
  input  wire logic shared_data_pin,  // Shared line
  input  wire logic tw    // Three-wire in use
);
  logic [7:0] rx [0:3]; // Bytes caught per slot
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
  // Clock stands still at the mode's idle level between frames
  task automatic frame(input logic m11, input logic rw, input logic [6:0] a,
                       input logic [7:0] wd, input int nbits);
    logic [15:0] sh;
    sh = {rw, a, wd};
    sck = m11;
    #100;
    cs_n = 1'b0;
    #63;
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      if (i < 16 && !(rw && i > 7)) mosi = sh[15-i];
      else mosi = ~mosi;
      #62;
      sck = 1'b1;
      if (i > 7) rx[(i-8)/8] = {rx[(i-8)/8][6:0], tw ? shared_data_pin : sdo};
      #63;
    end
    sck = m11;
    #63;
    cs_n = 1'b1;
    #2000;
  endtask
endmodule

/* tb/spirp_top_tb_top.sv */
// Purpose: self-checking bench for the serial register port
// Assumes: combinational register file model on reg_*
// Notes: link timing comes from the master model
`timescale 1ns/1ns
module spirp_top_tb_top;
  logic       clk, nrst, psel, tog_q, sdo_w, sdx_w, cs_n, sck, mosi;
  logic       sdx_out, sdx_oe, dout, dout_oe, wr, rd, twe, m11;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic [7:0] mem [0:127];
  int         miscompares, num_checks, nwr, n0;
  // Undriven wires toggle so a stale value cannot pass
  assign sdo_w = dout_oe ? dout : tog_q;
  assign sdx_w = sdx_oe ? sdx_out : mosi;
  assign rdata = mem[addr];
  always #4 clk = ~clk;
  always @(posedge clk) begin
    tog_q <= ~tog_q;
    if (wr === 1'b1) begin
      mem[addr] <= wdata;
      nwr <= nwr + 1;
    end
  end
  spirp_top u_spirp_top (.clk(clk), .nrst(nrst), .protocol_select_pin(psel),
    .chip_select_n(cs_n), .shared_clock_pin(sck), .shared_data_in(sdx_w),
    .shared_data_out(sdx_out), .shared_data_oe(sdx_oe), .data_out_pin(dout),
    .data_out_oe(dout_oe), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .three_wire_enable(twe), .clock_mode_11(m11));
  spirp_master u_spirp_master (.cs_n(cs_n), .sck(sck), .mosi(mosi),
    .sdo(sdo_w), .shared_data_pin(sdx_w), .tw(twe));
  function automatic logic [7:0] pat(input int i);
    return 8'(i) ^ 8'hA5;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Extra byte after the write data must be ignored
  task automatic t_write;
    n0 = nwr;
    u_spirp_master.frame(1'b0, 1'b0, 7'h10, 8'h5A, 24);
    chk(mem[16], 8'h5A);
    chk(8'(nwr - n0), 8'h01);
  endtask
  task automatic t_burst;
    u_spirp_master.frame(1'b1, 1'b1, 7'h02, 8'h00, 32);
    chk({7'h00, m11}, 8'h01);
    for (int i = 0; i < 3; i++) chk(u_spirp_master.rx[i], pat(2 + i));
  endtask
  task automatic t_fifo;
    u_spirp_master.frame(1'b0, 1'b1, 7'h3F, 8'h00, 24);
    chk({7'h00, m11}, 8'h00);
    chk(u_spirp_master.rx[0], pat(63));
    chk(u_spirp_master.rx[1], pat(63));
  endtask
  // Select rises after four data bits
  task automatic t_abort;
    n0 = nwr;
    u_spirp_master.frame(1'b0, 1'b0, 7'h11, 8'h33, 12);
    chk(mem[17], pat(17));
    chk(8'(nwr - n0), 8'h00);
    u_spirp_master.frame(1'b1, 1'b0, 7'h11, 8'h33, 16);
    chk(mem[17], 8'h33);
  endtask
  task automatic t_three;
    u_spirp_master.frame(1'b0, 1'b0, 7'h34, 8'h04, 16);
    chk({7'h00, twe}, 8'h01);
    u_spirp_master.frame(1'b1, 1'b1, 7'h05, 8'h00, 24);
    chk(u_spirp_master.rx[0], pat(5));
    chk(u_spirp_master.rx[1], pat(6));
    chk({6'h00, sdx_oe, dout_oe}, 8'h00);
    u_spirp_master.frame(1'b0, 1'b0, 7'h34, 8'h00, 16);
    chk({7'h00, twe}, 8'h00);
  endtask
  // Reset in mid-run drops the port back to four-wire
  task automatic t_reset;
    u_spirp_master.frame(1'b0, 1'b0, 7'h34, 8'h04, 16);
    chk({7'h00, twe}, 8'h01);
    @(negedge clk) nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk({4'h0, sdx_oe, dout_oe, twe, m11}, 8'h00);
    u_spirp_master.frame(1'b0, 1'b1, 7'h20, 8'h00, 16);
    chk(u_spirp_master.rx[0], pat(32));
  endtask
  task automatic t_off;
    @(negedge clk) psel = 1'b1;
    u_spirp_master.frame(1'b0, 1'b0, 7'h12, 8'hC3, 16);
    chk(mem[18], pat(18));
    @(negedge clk) psel = 1'b0;
  endtask
  // Watchdog ends a hung run as a failure
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end
  initial begin
    clk = 1'b0;
    tog_q = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    nwr = 0;
    for (int i = 0; i < 128; i++) mem[i] = pat(i);
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk({6'h00, twe, m11}, 8'h00);
    t_write();
    t_burst();
    t_fifo();
    t_abort();
    t_three();
    t_reset();
    t_off();
    finish_test();
  end
endmodule
